// *** scpm_top.sv ***
// speed command source selection and speed profile mapping
// Overview of operation
// - analog source selected: duty command follows sampled speed pin level
// - analog: zero below standby level, linear to full scale, then saturates
// - pulse source: duty command tracks measured input duty cycle linearly
// - pulse source: input low beyond timeout forces zero command and stop
// - serial source: host writes duty register; speed pin only controls sleep
// - serial: pin below sleep threshold beyond delay enters sleep
// - serial: pin above exit level leaves sleep; zero host duty means standby
// - frequency source: command is input frequency over full-scale frequency, saturating
// - frequency source: input low beyond timeout forces zero command and stop
// - command or reference under one percent clamps reference to zero
// - top speed limit zero holds reference at zero
// - direct shape passes duty command through as reference
// - zero duty command stops motor for every shape
// - linear shape interpolates from low clamp to high clamp via breakpoints
// - from zero, start only once command exceeds first turn-on breakpoint
// - below first turn-off breakpoint, use larger of turn-off and low clamp speed
// - hold low clamp speed between first turn-off and low clamp breakpoints
// - interpolate through A to E to high clamp, hold up to second turn-off
// - from zero at top end, start only below second turn-on breakpoint
// - above second turn-off breakpoint, reference becomes second turn-off speed
// - staircase shape steps between low and high clamp, same breakpoints
// - staircase switches to next level abruptly at each breakpoint
`timescale 1ns/1ps
`default_nettype none
module scpm_top
  import scpm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] source_select,
  input wire logic [1:0] profile_shape,
  input wire logic [ADC_W-1:0] speed_pin_level,
  input wire logic speed_pin_digital,
  input wire logic [ADC_W-1:0] analog_standby_threshold,
  input wire logic [ADC_W-1:0] analog_full_scale_level,
  input wire logic [ADC_W-1:0] sleep_entry_threshold,
  input wire logic [ADC_W-1:0] sleep_exit_threshold,
  input wire logic [CNT_W-1:0] sleep_entry_delay,
  input wire logic [CNT_W-1:0] full_scale_period,
  input wire logic [DUTY_W-1:0] host_duty,
  input wire logic [DUTY_W-1:0] top_speed_limit,
  input wire logic [DUTY_W-1:0] first_turn_on_breakpoint,
  input wire logic [DUTY_W-1:0] first_turn_off_breakpoint,
  input wire logic [DUTY_W-1:0] low_clamp_breakpoint,
  input wire logic [DUTY_W-1:0] high_clamp_breakpoint,
  input wire logic [DUTY_W-1:0] second_turn_on_breakpoint,
  input wire logic [DUTY_W-1:0] second_turn_off_breakpoint,
  input wire logic [DUTY_W-1:0] low_clamp_velocity,
  input wire logic [DUTY_W-1:0] first_turn_off_velocity,
  input wire logic [DUTY_W-1:0] high_clamp_velocity,
  input wire logic [DUTY_W-1:0] second_turn_off_velocity,
  input wire logic [NUM_PTS*DUTY_W-1:0] point_duty,
  input wire logic [NUM_PTS*DUTY_W-1:0] point_velocity,
  output logic [DUTY_W-1:0] duty_command_r,
  output logic [DUTY_W-1:0] speed_reference_r,
  output logic motor_stop_r,
  output logic sleep_r
);
  logic pin_s1_r;
  logic pin_s2_r;
  logic [CNT_W-1:0] high_cnt;
  logic [CNT_W-1:0] period_cnt;
  logic [CNT_W-1:0] low_run;
  logic period_valid;
  logic [CNT_W-1:0] sleep_cnt_r;
  logic [DUTY_W-1:0] duty_nxt;
  logic [DUTY_W-1:0] ref_nxt;
  logic [DUTY_W-1:0] shaped;
  logic [DUTY_W-1:0] bd [0:6];
  logic [DUTY_W-1:0] bv [0:6];
  scpm_run_t run_r;
  scpm_run_t run_nxt;

  // pin synchroniser
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= speed_pin_digital;
      pin_s2_r <= pin_s1_r;
    end
  end

  scpm_period_meter u_meter (
    .clk(clk),
    .reset(reset),
    .pin_sync(pin_s2_r),
    .high_cnt_r(high_cnt),
    .period_cnt_r(period_cnt),
    .low_run_r(low_run),
    .period_valid_r(period_valid)
  );

  // breakpoint table: low clamp, A..E, high clamp
  assign bd[0] = low_clamp_breakpoint;
  assign bv[0] = low_clamp_velocity;
  assign bd[6] = high_clamp_breakpoint;
  assign bv[6] = high_clamp_velocity;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PTS; gi++)
    begin : g_pts
      assign bd[gi+1] = point_duty[gi*DUTY_W +: DUTY_W];
      assign bv[gi+1] = point_velocity[gi*DUTY_W +: DUTY_W];
    end
  endgenerate

  // duty command from the selected source
  always_comb
  begin
    logic [31:0] num;
    logic [31:0] den;
    num = '0;
    den = '0;
    duty_nxt = DUTY_ZERO;
    case (source_select)
      SRC_ANALOG:
      begin
        if (speed_pin_level >= analog_full_scale_level)
          duty_nxt = DUTY_FULL;
        else if (speed_pin_level > analog_standby_threshold)
        begin
          num = 32'(speed_pin_level - analog_standby_threshold) * 32'(DUTY_FULL);
          den = 32'(analog_full_scale_level - analog_standby_threshold);
          duty_nxt = DUTY_W'(num / den);
        end
      end
      SRC_PULSE:
      begin
        if (low_run >= CNT_W'(PULSE_SB_CYC))
          duty_nxt = DUTY_ZERO;
        else if (pin_s2_r && low_run == '0 && !period_valid)
          duty_nxt = DUTY_FULL;
        else if (period_valid)
          duty_nxt = DUTY_W'((32'(high_cnt) * 32'(DUTY_FULL)) / 32'(period_cnt));
      end
      SRC_SERIAL:
        duty_nxt = sleep_r ? DUTY_ZERO : host_duty;
      SRC_FREQ:
      begin
        if (low_run >= CNT_W'(FREQ_SB_CYC) || !period_valid)
          duty_nxt = DUTY_ZERO;
        else if (period_cnt <= full_scale_period)
          duty_nxt = DUTY_FULL;
        else
          duty_nxt = DUTY_W'((32'(full_scale_period) * 32'(DUTY_FULL)) / 32'(period_cnt));
      end
      default:
        duty_nxt = DUTY_ZERO;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      duty_command_r <= DUTY_ZERO;
    else
      duty_command_r <= duty_nxt;
  end

  // sleep entry and exit in serial mode
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sleep_cnt_r <= '0;
      sleep_r <= 1'b0;
    end
    else if (source_select != SRC_SERIAL)
    begin
      sleep_cnt_r <= '0;
      sleep_r <= 1'b0;
    end
    else if (speed_pin_level < sleep_entry_threshold)
    begin
      if (sleep_cnt_r >= sleep_entry_delay)
        sleep_r <= 1'b1;
      else
        sleep_cnt_r <= sleep_cnt_r + CNT_W'(1);
    end
    else
    begin
      sleep_cnt_r <= '0;
      if (speed_pin_level > sleep_exit_threshold)
        sleep_r <= 1'b0;
    end
  end

  // profile mapping of the registered duty command
  always_comb
  begin
    logic [DUTY_W-1:0] d;
    logic [DUTY_W-1:0] lowoff;
    logic [31:0] span;
    logic [31:0] dv;
    d = duty_command_r;
    lowoff = (first_turn_off_velocity > low_clamp_velocity) ?
      first_turn_off_velocity : low_clamp_velocity;
    span = '0;
    dv = '0;
    run_nxt = run_r;
    shaped = DUTY_ZERO;
    case (run_r)
      SCPM_OFF:
      begin
        if (d > first_turn_on_breakpoint && d < high_clamp_breakpoint)
          run_nxt = SCPM_LOW;
        else if (d < second_turn_on_breakpoint && d >= high_clamp_breakpoint)
          run_nxt = SCPM_HIGH;
      end
      SCPM_LOW:
        if (d >= high_clamp_breakpoint)
          run_nxt = SCPM_HIGH;
      SCPM_HIGH:
        if (d < high_clamp_breakpoint)
          run_nxt = SCPM_LOW;
      default:
        run_nxt = SCPM_OFF;
    endcase
    if (run_nxt == SCPM_HIGH)
      shaped = (d > second_turn_off_breakpoint) ? second_turn_off_velocity
        : high_clamp_velocity;
    else if (run_nxt == SCPM_LOW)
    begin
      if (d < first_turn_off_breakpoint)
        shaped = lowoff;
      else
      begin
        shaped = low_clamp_velocity;
        for (int k = 0; k < 6; k++)
        begin
          if (d >= bd[k] && d < bd[k+1])
          begin
            if (profile_shape == SHAPE_STAIR)
              shaped = bv[k+1];
            else
            begin
              span = 32'(bd[k+1] - bd[k]);
              dv = (bv[k+1] >= bv[k]) ?
                32'(bv[k]) + (32'(bv[k+1] - bv[k]) * 32'(d - bd[k])) / span :
                32'(bv[k]) - (32'(bv[k] - bv[k+1]) * 32'(d - bd[k])) / span;
              shaped = DUTY_W'(dv);
            end
          end
        end
      end
    end
    if (profile_shape == SHAPE_DIRECT)
      shaped = d;
    ref_nxt = shaped;
    if (d == DUTY_ZERO)
      ref_nxt = DUTY_ZERO;
    if (d < DUTY_ONE_PCT || shaped < DUTY_ONE_PCT)
      ref_nxt = DUTY_ZERO;
    if (top_speed_limit == DUTY_ZERO)
      ref_nxt = DUTY_ZERO;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      run_r <= SCPM_OFF;
    else if (profile_shape == SHAPE_DIRECT || ref_nxt == DUTY_ZERO && run_nxt == run_r
             && duty_command_r == DUTY_ZERO)
      run_r <= SCPM_OFF;
    else
      run_r <= run_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      speed_reference_r <= DUTY_ZERO;
      motor_stop_r <= 1'b1;
    end
    else
    begin
      speed_reference_r <= ref_nxt;
      motor_stop_r <= (ref_nxt == DUTY_ZERO);
    end
  end

  a_zero_limit_stop: assert property (@(posedge clk) disable iff (reset)
    top_speed_limit == DUTY_ZERO |=> speed_reference_r == DUTY_ZERO)
    else $error("reference not zero under zero limit");
  a_zero_duty_stop: assert property (@(posedge clk) disable iff (reset)
    duty_command_r == DUTY_ZERO |=> motor_stop_r)
    else $error("motor runs at zero duty");
  a_small_ref_clamp: assert property (@(posedge clk) disable iff (reset)
    speed_reference_r != DUTY_ZERO |-> speed_reference_r >= DUTY_ONE_PCT)
    else $error("reference below one percent");
  a_direct_pass: assert property (@(posedge clk) disable iff (reset)
    profile_shape == SHAPE_DIRECT && top_speed_limit != DUTY_ZERO
    && duty_command_r >= DUTY_ONE_PCT |=> speed_reference_r == $past(duty_command_r))
    else $error("direct shape altered command");
  a_analog_full: assert property (@(posedge clk) disable iff (reset)
    source_select == SRC_ANALOG && speed_pin_level >= analog_full_scale_level
    |=> duty_command_r == DUTY_FULL)
    else $error("analog not saturated");
  a_analog_low: assert property (@(posedge clk) disable iff (reset)
    source_select == SRC_ANALOG && speed_pin_level <= analog_standby_threshold
    && speed_pin_level < analog_full_scale_level |=> duty_command_r == DUTY_ZERO)
    else $error("analog not zero below standby");
  a_pulse_timeout: assert property (@(posedge clk) disable iff (reset)
    source_select == SRC_PULSE && low_run >= CNT_W'(PULSE_SB_CYC)
    |=> duty_command_r == DUTY_ZERO)
    else $error("pulse timeout ignored");
  a_freq_timeout: assert property (@(posedge clk) disable iff (reset)
    source_select == SRC_FREQ && low_run >= CNT_W'(FREQ_SB_CYC)
    |=> duty_command_r == DUTY_ZERO)
    else $error("frequency timeout ignored");
  a_sleep_zero: assert property (@(posedge clk) disable iff (reset)
    source_select == SRC_SERIAL && sleep_r |=> duty_command_r == DUTY_ZERO)
    else $error("duty while asleep");
  c_sleep_entry: cover property (@(posedge clk) $rose(sleep_r));
  c_motor_start: cover property (@(posedge clk) $fell(motor_stop_r));
  c_stair_run: cover property (@(posedge clk) profile_shape == SHAPE_STAIR && !motor_stop_r);
endmodule
`default_nettype wire

// *** scpm_pkg.sv ***
// package of constants and types for the speed command profile mapper
package scpm_pkg;
  localparam int DUTY_W = 10;
  localparam logic [9:0] DUTY_FULL = 10'h3E8;
  localparam logic [9:0] DUTY_ONE_PCT = 10'h00A;
  localparam logic [9:0] DUTY_ZERO = 10'h000;
  localparam int ADC_W = 12;
  localparam int CNT_W = 24;
  localparam int NUM_PTS = 5;
  localparam int CLK_MHZ = 200;
  localparam int PULSE_SB_TIMEOUT_US = 20;
  localparam int PULSE_SB_CYC = PULSE_SB_TIMEOUT_US * CLK_MHZ;
  localparam int FREQ_SB_TIMEOUT_US = 20;
  localparam int FREQ_SB_CYC = FREQ_SB_TIMEOUT_US * CLK_MHZ;
  localparam logic [1:0] SRC_ANALOG = 2'h0;
  localparam logic [1:0] SRC_PULSE = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  localparam logic [1:0] SRC_FREQ = 2'h3;
  localparam logic [1:0] SHAPE_DIRECT = 2'h0;
  localparam logic [1:0] SHAPE_LINEAR = 2'h1;
  localparam logic [1:0] SHAPE_STAIR = 2'h2;
  typedef enum logic [1:0] {SCPM_OFF, SCPM_LOW, SCPM_HIGH} scpm_run_t;
endpackage

// *** scpm_period_meter.sv ***
// measures high time and period of the speed pin square wave
`timescale 1ns/1ps
`default_nettype none
module scpm_period_meter
  import scpm_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_sync,
  output logic [CNT_W-1:0] high_cnt_r,
  output logic [CNT_W-1:0] period_cnt_r,
  output logic [CNT_W-1:0] low_run_r,
  output logic period_valid_r
);
  logic pin_d_r;
  logic [CNT_W-1:0] hcnt_r;
  logic [CNT_W-1:0] pcnt_r;
  logic rise;
  assign rise = pin_sync & ~pin_d_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_d_r <= 1'b0;
      hcnt_r <= '0;
      pcnt_r <= '0;
      high_cnt_r <= '0;
      period_cnt_r <= '0;
      period_valid_r <= 1'b0;
    end
    else
    begin
      pin_d_r <= pin_sync;
      if (rise)
      begin
        high_cnt_r <= hcnt_r;
        period_cnt_r <= pcnt_r;
        period_valid_r <= (pcnt_r != '0);
        hcnt_r <= CNT_W'(1);
        pcnt_r <= CNT_W'(1);
      end
      else
      begin
        if (pin_sync && hcnt_r != '1)
          hcnt_r <= hcnt_r + CNT_W'(1);
        if (pcnt_r != '1)
          pcnt_r <= pcnt_r + CNT_W'(1);
      end
    end
  end

  // length of the present continuous low stretch
  always_ff @(posedge clk)
  begin
    if (reset)
      low_run_r <= '0;
    else if (pin_sync)
      low_run_r <= '0;
    else if (low_run_r != '1)
      low_run_r <= low_run_r + CNT_W'(1);
  end
endmodule
`default_nettype wire

// *** scpm_host.sv ***
// host side model: drives the speed pin level, pin waveform and host duty
`timescale 1ns/1ps
`default_nettype none
module scpm_host
  import scpm_pkg::*;
(
  input wire logic clk,
  output logic [ADC_W-1:0] pin_level,
  output logic pin_digital,
  output logic [DUTY_W-1:0] host_duty
);
  logic [15:0] per_r = 16'h0000;
  logic [15:0] hi_r = 16'h0000;
  logic [15:0] cnt_r = 16'h0000;
  initial
  begin
    pin_level = 12'h000;
    host_duty = 10'h000;
  end
  // hi_r high cycles out of per_r; a zero period holds the pin steady
  always @(negedge clk)
  begin
    cnt_r <= (cnt_r + 16'h0001 >= per_r) ? 16'h0000 : cnt_r + 16'h0001;
  end
  assign pin_digital = (per_r == 16'h0000) ? (hi_r != 16'h0000) : (cnt_r < hi_r);
  task automatic wave(input logic [15:0] p, input logic [15:0] h);
    per_r = p;
    hi_r = h;
  endtask
  task automatic level(input logic [ADC_W-1:0] l);
    pin_level = l;
  endtask
  task automatic duty(input logic [DUTY_W-1:0] d);
    host_duty = d;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the speed command profile mapper
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import scpm_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] source_select = SRC_ANALOG;
  logic [1:0] profile_shape = SHAPE_DIRECT;
  logic [ADC_W-1:0] speed_pin_level;
  logic speed_pin_digital;
  logic [DUTY_W-1:0] host_duty;
  logic [DUTY_W-1:0] top_speed_limit = 10'h3E8;
  logic [DUTY_W-1:0] first_turn_off_velocity = 10'h096;
  logic [ADC_W-1:0] analog_standby_threshold = 12'h100;
  logic [ADC_W-1:0] analog_full_scale_level = 12'h500;
  logic [ADC_W-1:0] sleep_entry_threshold = 12'h200;
  logic [ADC_W-1:0] sleep_exit_threshold = 12'h400;
  logic [CNT_W-1:0] sleep_entry_delay = 24'h000032;
  logic [CNT_W-1:0] full_scale_period = 24'h000064;
  logic [DUTY_W-1:0] first_turn_on_breakpoint = 10'h064;
  logic [DUTY_W-1:0] first_turn_off_breakpoint = 10'h050;
  logic [DUTY_W-1:0] low_clamp_breakpoint = 10'h096;
  logic [DUTY_W-1:0] high_clamp_breakpoint = 10'h320;
  logic [DUTY_W-1:0] second_turn_on_breakpoint = 10'h384;
  logic [DUTY_W-1:0] second_turn_off_breakpoint = 10'h3B6;
  logic [DUTY_W-1:0] low_clamp_velocity = 10'h0C8;
  logic [DUTY_W-1:0] high_clamp_velocity = 10'h384;
  logic [DUTY_W-1:0] second_turn_off_velocity = 10'h064;
  logic [NUM_PTS*DUTY_W-1:0] point_duty = {10'h258, 10'h1F4, 10'h190, 10'h12C, 10'h0C8};
  logic [NUM_PTS*DUTY_W-1:0] point_velocity = {10'h2BC, 10'h258, 10'h1F4, 10'h190, 10'h12C};
  logic [DUTY_W-1:0] duty_command_r;
  logic [DUTY_W-1:0] speed_reference_r;
  logic motor_stop_r;
  logic sleep_r;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  scpm_host i_scpm_host (
    .clk(clk),
    .pin_level(speed_pin_level),
    .pin_digital(speed_pin_digital),
    .host_duty(host_duty)
  );
  scpm_top i_scpm_top (
    .clk(clk),
    .reset(reset),
    .source_select(source_select),
    .profile_shape(profile_shape),
    .speed_pin_level(speed_pin_level),
    .speed_pin_digital(speed_pin_digital),
    .analog_standby_threshold(analog_standby_threshold),
    .analog_full_scale_level(analog_full_scale_level),
    .sleep_entry_threshold(sleep_entry_threshold),
    .sleep_exit_threshold(sleep_exit_threshold),
    .sleep_entry_delay(sleep_entry_delay),
    .full_scale_period(full_scale_period),
    .host_duty(host_duty),
    .top_speed_limit(top_speed_limit),
    .first_turn_on_breakpoint(first_turn_on_breakpoint),
    .first_turn_off_breakpoint(first_turn_off_breakpoint),
    .low_clamp_breakpoint(low_clamp_breakpoint),
    .high_clamp_breakpoint(high_clamp_breakpoint),
    .second_turn_on_breakpoint(second_turn_on_breakpoint),
    .second_turn_off_breakpoint(second_turn_off_breakpoint),
    .low_clamp_velocity(low_clamp_velocity),
    .first_turn_off_velocity(first_turn_off_velocity),
    .high_clamp_velocity(high_clamp_velocity),
    .second_turn_off_velocity(second_turn_off_velocity),
    .point_duty(point_duty),
    .point_velocity(point_velocity),
    .duty_command_r(duty_command_r),
    .speed_reference_r(speed_reference_r),
    .motor_stop_r(motor_stop_r),
    .sleep_r(sleep_r)
  );
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [DUTY_W-1:0] e, input logic [DUTY_W-1:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
      fails++;
    end
  endtask
  // measured sources may be off by one percent from edge alignment
  task automatic chk_near(input string nm, input logic [DUTY_W-1:0] e, input logic [DUTY_W-1:0] g);
    tests_run++;
    if (((g + 10'h00A >= e) && (g <= e + 10'h00A)) !== 1'b1)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic put(input logic [DUTY_W-1:0] d, input logic [DUTY_W-1:0] e);
    i_scpm_host.duty(d);
    cyc(3);
    chk("speed_reference", e, speed_reference_r);
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  initial
  begin
    cyc(4);
    reset = 1'b0;
    i_scpm_host.level(12'h300);
    cyc(3);
    chk("duty_command", 10'h1F4, duty_command_r);
    chk("speed_reference", 10'h1F4, speed_reference_r);
    i_scpm_host.level(12'h080);
    cyc(3);
    chk("duty_command", 10'h000, duty_command_r);
    chk_bit("motor_stop", 1'b1, motor_stop_r);
    i_scpm_host.level(12'h600);
    cyc(3);
    chk("duty_command", 10'h3E8, duty_command_r);
    top_speed_limit = 10'h000;
    cyc(3);
    chk("speed_reference", 10'h000, speed_reference_r);
    chk_bit("motor_stop", 1'b1, motor_stop_r);
    top_speed_limit = 10'h3E8;
    analog_standby_threshold = 12'h200;
    analog_full_scale_level = 12'h600;
    i_scpm_host.level(12'h300);
    cyc(3);
    chk("duty_command", 10'h0FA, duty_command_r);
    done("analog");
    source_select = SRC_PULSE;
    i_scpm_host.wave(16'h0064, 16'h0019);
    cyc(1000);
    chk_near("duty_command", 10'h0FA, duty_command_r);
    i_scpm_host.wave(16'h0000, 16'h0000);
    cyc(4030);
    chk("duty_command", 10'h000, duty_command_r);
    chk_bit("motor_stop", 1'b1, motor_stop_r);
    done("pulse");
    source_select = SRC_FREQ;
    i_scpm_host.wave(16'h00C8, 16'h0064);
    cyc(2000);
    chk_near("duty_command", 10'h1F4, duty_command_r);
    full_scale_period = 24'h000032;
    cyc(3);
    chk_near("duty_command", 10'h0FA, duty_command_r);
    i_scpm_host.wave(16'h0032, 16'h0019);
    cyc(1000);
    chk("duty_command", 10'h3E8, duty_command_r);
    i_scpm_host.wave(16'h0000, 16'h0000);
    cyc(4030);
    chk("duty_command", 10'h000, duty_command_r);
    chk_bit("motor_stop", 1'b1, motor_stop_r);
    done("frequency");
    source_select = SRC_SERIAL;
    i_scpm_host.level(12'h800);
    put(10'h12C, 10'h12C);
    put(10'h005, 10'h000);
    chk_bit("motor_stop", 1'b1, motor_stop_r);
    i_scpm_host.duty(10'h12C);
    i_scpm_host.level(12'h100);
    cyc(30);
    chk_bit("sleep", 1'b0, sleep_r);
    cyc(40);
    chk_bit("sleep", 1'b1, sleep_r);
    chk("duty_command", 10'h000, duty_command_r);
    i_scpm_host.level(12'h800);
    cyc(5);
    chk_bit("sleep", 1'b0, sleep_r);
    chk("speed_reference", 10'h12C, speed_reference_r);
    put(10'h000, 10'h000);
    chk_bit("motor_stop", 1'b1, motor_stop_r);
    sleep_entry_delay = 24'h000014;
    sleep_entry_threshold = 12'h300;
    sleep_exit_threshold = 12'h600;
    i_scpm_host.level(12'h280);
    cyc(30);
    chk_bit("sleep", 1'b1, sleep_r);
    i_scpm_host.level(12'h500);
    cyc(5);
    chk_bit("sleep", 1'b1, sleep_r);
    i_scpm_host.level(12'h700);
    cyc(5);
    chk_bit("sleep", 1'b0, sleep_r);
    done("serial");
    profile_shape = SHAPE_LINEAR;
    put(10'h05A, 10'h000);
    put(10'h078, 10'h0C8);
    put(10'h046, 10'h0C8);
    first_turn_off_velocity = 10'h12C;
    put(10'h046, 10'h12C);
    put(10'h0FA, 10'h15E);
    put(10'h2BC, 10'h320);
    put(10'h352, 10'h384);
    put(10'h3C0, 10'h064);
    put(10'h000, 10'h000);
    put(10'h3C0, 10'h000);
    put(10'h352, 10'h384);
    done("linear");
    profile_shape = SHAPE_STAIR;
    put(10'h0B4, 10'h12C);
    put(10'h0FA, 10'h190);
    put(10'h28A, 10'h384);
    put(10'h000, 10'h000);
    done("staircase");
    profile_shape = SHAPE_LINEAR;
    low_clamp_velocity = 10'h0FA;
    point_velocity = {10'h320, 10'h2BC, 10'h258, 10'h1F4, 10'h190};
    high_clamp_velocity = 10'h3B6;
    second_turn_off_velocity = 10'h0C8;
    first_turn_off_breakpoint = 10'h078;
    second_turn_off_breakpoint = 10'h3A2;
    put(10'h0B4, 10'h154);
    put(10'h06E, 10'h12C);
    put(10'h352, 10'h3B6);
    put(10'h3A7, 10'h0C8);
    put(10'h2BC, 10'h36B);
    done("reprofiled");
    end_of_test();
  end
endmodule
`default_nettype wire
